// *** hdl/gpio_port_regs.vh ***
// Register map, reset values and field constants of the port block
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

`define OFS_DATA_LAST 12'h3fc
`define OFS_DIR 12'h400
`define OFS_IS 12'h404
`define OFS_IBE 12'h408
`define OFS_IEV 12'h40c
`define OFS_IM 12'h410
`define OFS_RIS 12'h414
`define OFS_MIS 12'h418
`define OFS_ICR 12'h41c
`define OFS_AFSEL 12'h420
`define OFS_DR2R 12'h500
`define OFS_DR4R 12'h504
`define OFS_DR8R 12'h508
`define OFS_ODR 12'h50c
`define OFS_PUR 12'h510
`define OFS_PDR 12'h514
`define OFS_SLR 12'h518
`define OFS_DEN 12'h51c
`define OFS_LOCK 12'h520
`define OFS_CR 12'h524
`define OFS_ID_FIRST 12'hfd0
`define OFS_ID_LAST 12'hffc

`define RST_ZERO 8'h00
`define RST_DR2R 8'hff
`define RST_LOCKED 32'h0000_0001
`define UNLOCK_KEY 32'h0123_4567

`endif

// *** hdl/gpio_port.v ***
// One eight-pin general-purpose port with APB register access
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "gpio_port_regs.vh"

module gpio_port #(
  // Every port is this one module; only these two parameters differ between ports
  // Debug-pin defaults per port; zero for an ordinary port
  parameter [7:0] DEBUG_PINS = 8'h00,
  // Identification bytes, offsets 0xfd0..0xffc, lowest offset in low byte; values arbitrary
  parameter [95:0] ID_BYTES = 96'h5a_a5_3c_c3_11_22_33_44_00_00_00_00
) (
  input wire clk_sys,
  input wire srst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  input wire [7:0] periph_out,
  input wire [7:0] periph_oe,
  output reg [7:0] periph_in,
  output reg [7:0] pad_drive_low,
  output reg [7:0] pad_drive_mid,
  output reg [7:0] pad_drive_high,
  output reg [7:0] pad_open_drain,
  output reg [7:0] pad_pullup,
  output reg [7:0] pad_pulldown,
  output reg [7:0] pad_slew_limit,
  output reg [7:0] pad_input_enable,
  output reg port_irq
);

  // Register state
  // Each control register except the lock holds one bit per pin, bit n for pin n
  reg [7:0] port_value_reg;
  reg [7:0] pin_direction_reg;
  reg [7:0] trigger_kind_select;
  reg [7:0] dual_edge_select;
  reg [7:0] trigger_polarity_select;
  reg [7:0] irq_enable_mask;
  reg [7:0] raw_irq_flags;
  reg [7:0] peripheral_handover_select;
  reg [7:0] drive_low_select;
  reg [7:0] drive_mid_select;
  reg [7:0] drive_high_select;
  reg [7:0] open_drain_select;
  reg [7:0] pullup_select;
  reg [7:0] pulldown_select;
  reg [7:0] edge_rate_limit;
  reg [7:0] digital_input_enable;
  reg write_guard_locked;
  reg [7:0] protected_bit_commit;
  reg [7:0] pin_sample;
  reg [7:0] pin_prev;

  // Decode and datapath nets
  wire [7:0] gated_irq_flags;
  wire [7:0] irq_hit;
  wire [7:0] mask_bits;
  wire [7:0] wbyte;
  wire setup_cycle;
  wire wr_take;
  wire data_hit;
  wire id_hit;
  wire [3:0] id_index;
  wire [7:0] afsel_keep;
  wire [7:0] clear_bits;
  wire [7:0] next_raw_flags;

  reg [31:0] next_prdata;
  reg next_slverr;

  assign setup_cycle = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;
  assign mask_bits = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign data_hit = (paddr <= `OFS_DATA_LAST);
  assign id_hit = (paddr >= `OFS_ID_FIRST);
  assign id_index = paddr[5:2] - 4'h4;
  assign gated_irq_flags = raw_irq_flags & irq_enable_mask;
  assign clear_bits = (wr_take && paddr == `OFS_ICR) ? wbyte : 8'h00;
  // Level bits follow the input; edge bits latch until a one is written to clear them.
  // A hit in the clearing cycle wins, so an edge that races the clear is never lost.
  assign next_raw_flags = (raw_irq_flags & ~clear_bits & ~trigger_kind_select) | irq_hit;
  // Ordinary bits follow any write; debug bits need the key and a commit bit, so a
  // locked port still lets software hand its ordinary pins to a peripheral
  assign afsel_keep = ~DEBUG_PINS | (protected_bit_commit & {8{~write_guard_locked}});

  // Per-pin trigger detection; each bit is the same circuit
  // Edges compare two registered samples, so a hit shows one edge after the sample
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : trig
      wire rise;
      wire fall;
      wire edge_hit;
      wire level_hit;
      assign rise = pin_sample[g] & ~pin_prev[g];
      assign fall = ~pin_sample[g] & pin_prev[g];
      // Dual edge overrides polarity
      assign edge_hit = dual_edge_select[g] ? (rise | fall) :
        (trigger_polarity_select[g] ? rise : fall);
      // Level follows the input, relying on the source to hold it
      assign level_hit = trigger_polarity_select[g] ? pin_sample[g] : ~pin_sample[g];
      assign irq_hit[g] = trigger_kind_select[g] ? level_hit : edge_hit;
    end
  endgenerate

  // Read mux, evaluated in the setup cycle and registered for the access phase
  // Data reads take stored bits for outputs and sampled bits for inputs, then mask
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    // Unmapped offsets answer with an error and zero data; writes to them are dropped
    if (data_hit) begin
      next_prdata = {24'h00_0000, mask_bits & ((pin_direction_reg & port_value_reg) |
        (~pin_direction_reg & pin_sample))};
    end else if (paddr == `OFS_DIR) begin
      next_prdata = {24'h00_0000, pin_direction_reg};
    end else if (paddr == `OFS_IS) begin
      next_prdata = {24'h00_0000, trigger_kind_select};
    end else if (paddr == `OFS_IBE) begin
      next_prdata = {24'h00_0000, dual_edge_select};
    end else if (paddr == `OFS_IEV) begin
      next_prdata = {24'h00_0000, trigger_polarity_select};
    end else if (paddr == `OFS_IM) begin
      next_prdata = {24'h00_0000, irq_enable_mask};
    end else if (paddr == `OFS_RIS) begin
      next_prdata = {24'h00_0000, raw_irq_flags};
    end else if (paddr == `OFS_MIS) begin
      next_prdata = {24'h00_0000, gated_irq_flags};
    end else if (paddr == `OFS_ICR) begin
      next_prdata = 32'h0000_0000;
    end else if (paddr == `OFS_AFSEL) begin
      next_prdata = {24'h00_0000, peripheral_handover_select};
    end else if (paddr == `OFS_DR2R) begin
      next_prdata = {24'h00_0000, drive_low_select};
    end else if (paddr == `OFS_DR4R) begin
      next_prdata = {24'h00_0000, drive_mid_select};
    end else if (paddr == `OFS_DR8R) begin
      next_prdata = {24'h00_0000, drive_high_select};
    end else if (paddr == `OFS_ODR) begin
      next_prdata = {24'h00_0000, open_drain_select};
    end else if (paddr == `OFS_PUR) begin
      next_prdata = {24'h00_0000, pullup_select};
    end else if (paddr == `OFS_PDR) begin
      next_prdata = {24'h00_0000, pulldown_select};
    end else if (paddr == `OFS_SLR) begin
      next_prdata = {24'h00_0000, edge_rate_limit};
    end else if (paddr == `OFS_DEN) begin
      next_prdata = {24'h00_0000, digital_input_enable};
    end else if (paddr == `OFS_LOCK) begin
      next_prdata = {31'h0000_0000, write_guard_locked};
    end else if (paddr == `OFS_CR) begin
      next_prdata = {24'h00_0000, protected_bit_commit};
    end else if (id_hit && paddr[1:0] == 2'b00) begin
      next_prdata = {24'h00_0000, ID_BYTES[id_index * 8 +: 8]};
    end else begin
      next_slverr = 1'b1;
    end
  end

  // APB handshake: ready comes in the access cycle right after setup, no wait states;
  // the answer stands for that one cycle, then the outputs fall back to zero
  always @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_cycle) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_slverr;
    end else begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Data register: masked byte write
  // Bits outside the address mask keep their value, so no read-modify-write is needed
  always @(posedge clk_sys) begin
    if (srst) begin
      port_value_reg <= `RST_ZERO;
    end else if (wr_take && data_hit) begin
      port_value_reg <= (port_value_reg & ~mask_bits) | (wbyte & mask_bits);
    end
  end

  // Direction and interrupt trigger configuration; software is expected to mask first
  // A write here may raise a spurious flag on an unmasked pin; nothing filters it
  always @(posedge clk_sys) begin
    if (srst) begin
      pin_direction_reg <= `RST_ZERO;
      trigger_kind_select <= `RST_ZERO;
      dual_edge_select <= `RST_ZERO;
      trigger_polarity_select <= `RST_ZERO;
      irq_enable_mask <= `RST_ZERO;
    end else if (wr_take) begin
      if (paddr == `OFS_DIR) begin
        pin_direction_reg <= wbyte;
      end else if (paddr == `OFS_IS) begin
        trigger_kind_select <= wbyte;
      end else if (paddr == `OFS_IBE) begin
        dual_edge_select <= wbyte;
      end else if (paddr == `OFS_IEV) begin
        trigger_polarity_select <= wbyte;
      end else if (paddr == `OFS_IM) begin
        irq_enable_mask <= wbyte;
      end
    end
  end

  // Raw flags: edges latch until cleared, a new hit beats a clear in the same cycle
  // Level bits are not sticky: they drop as soon as the input leaves the active level
  // The raw view ignores the mask, so software can poll a masked pin
  always @(posedge clk_sys) begin
    if (srst) begin
      raw_irq_flags <= `RST_ZERO;
    end else begin
      raw_irq_flags <= next_raw_flags;
    end
  end

  // Pad and handover configuration; debug pins come back to debug use on reset
  // Slew bits are stored for every pin; only the pad copy is gated by 8 mA
  always @(posedge clk_sys) begin
    if (srst) begin
      peripheral_handover_select <= DEBUG_PINS;
      pullup_select <= DEBUG_PINS;
      digital_input_enable <= DEBUG_PINS;
      pulldown_select <= `RST_ZERO;
      drive_low_select <= `RST_DR2R;
      drive_mid_select <= `RST_ZERO;
      drive_high_select <= `RST_ZERO;
      open_drain_select <= `RST_ZERO;
      edge_rate_limit <= `RST_ZERO;
    end else if (wr_take) begin
      if (paddr == `OFS_AFSEL) begin
        peripheral_handover_select <= (peripheral_handover_select & ~afsel_keep) |
          (wbyte & afsel_keep);
      end else if (paddr == `OFS_DR2R) begin
        // Drive selections are exclusive: setting one clears the others
        drive_low_select <= drive_low_select | wbyte;
        drive_mid_select <= drive_mid_select & ~wbyte;
        drive_high_select <= drive_high_select & ~wbyte;
      end else if (paddr == `OFS_DR4R) begin
        drive_low_select <= drive_low_select & ~wbyte;
        drive_mid_select <= drive_mid_select | wbyte;
        drive_high_select <= drive_high_select & ~wbyte;
      end else if (paddr == `OFS_DR8R) begin
        drive_low_select <= drive_low_select & ~wbyte;
        drive_mid_select <= drive_mid_select & ~wbyte;
        drive_high_select <= drive_high_select | wbyte;
      end else if (paddr == `OFS_ODR) begin
        open_drain_select <= wbyte;
      end else if (paddr == `OFS_PUR) begin
        pullup_select <= wbyte;
      end else if (paddr == `OFS_PDR) begin
        pulldown_select <= wbyte;
      end else if (paddr == `OFS_SLR) begin
        edge_rate_limit <= wbyte;
      end else if (paddr == `OFS_DEN) begin
        digital_input_enable <= wbyte;
      end
    end
  end

  // Lock and commit: only the debug pins start guarded; any wrong key relocks
  // The key compare uses all 32 data bits, so a stray byte write cannot unlock
  always @(posedge clk_sys) begin
    if (srst) begin
      write_guard_locked <= `RST_LOCKED == 32'h0000_0001;
      protected_bit_commit <= ~DEBUG_PINS;
    end else if (wr_take && paddr == `OFS_LOCK) begin
      write_guard_locked <= (pwdata != `UNLOCK_KEY);
    end else if (wr_take && paddr == `OFS_CR && !write_guard_locked) begin
      // Only guarded pins have writable commit bits; the others stay committed
      protected_bit_commit <= ~DEBUG_PINS | (wbyte & DEBUG_PINS);
    end
  end

  // Pin sampling and output drive, all registered
  // One sampling stage only: pin inputs are synchronous to the clock here
  always @(posedge clk_sys) begin
    if (srst) begin
      pin_sample <= 8'h00;
      pin_prev <= 8'h00;
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      periph_in <= 8'h00;
      port_irq <= 1'b0;
    end else begin
      // Disabled inputs read as zero so a floating pad never toggles; a low-level trigger still fires on it
      pin_sample <= pin_in & digital_input_enable;
      pin_prev <= pin_sample;
      // Peripheral input is gated the same way, so a disabled pad reads zero there too
      periph_in <= pin_in & digital_input_enable & peripheral_handover_select;
      // Handover picks the owner; open drain only ever drives low
      pin_out <= (peripheral_handover_select & periph_out) |
        (~peripheral_handover_select & port_value_reg);
      // Open-drain pins release the line for a one and leave the pull to lift it
      pin_oe <= ((peripheral_handover_select & periph_oe) |
        (~peripheral_handover_select & pin_direction_reg)) &
        ~(open_drain_select & ((peripheral_handover_select & periph_out) |
        (~peripheral_handover_select & port_value_reg)));
      // Interrupt uses the flags' next value so it rises and falls with the status bits
      port_irq <= |(next_raw_flags & irq_enable_mask);
    end
  end

  // Pad controls as registered copies; slew only where 8 mA is chosen
  // Pads lag a register write by one edge; nothing inside the block relies on it sooner
  always @(posedge clk_sys) begin
    if (srst) begin
      pad_drive_low <= `RST_DR2R;
      pad_drive_mid <= 8'h00;
      pad_drive_high <= 8'h00;
      pad_open_drain <= 8'h00;
      pad_pullup <= DEBUG_PINS;
      pad_pulldown <= 8'h00;
      pad_slew_limit <= 8'h00;
      pad_input_enable <= DEBUG_PINS;
    end else begin
      pad_drive_low <= drive_low_select;
      pad_drive_mid <= drive_mid_select;
      pad_drive_high <= drive_high_select;
      pad_open_drain <= open_drain_select;
      pad_pullup <= pullup_select;
      pad_pulldown <= pulldown_select;
      pad_slew_limit <= edge_rate_limit & drive_high_select;
      pad_input_enable <= digital_input_enable;
    end
  end

endmodule

// *** sim/gpio_port_properties.sv ***
// Concurrent checks on the port block's APB answer and pad outputs
`timescale 1ns/1ps
module gpio_port_properties #(
  parameter [7:0] DEBUG_PINS = 8'h00
) (
  input wire clk_sys,
  input wire srst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] pin_oe,
  input wire [7:0] pad_drive_low,
  input wire [7:0] pad_drive_mid,
  input wire [7:0] pad_drive_high,
  input wire [7:0] pad_pullup,
  input wire [7:0] pad_pulldown,
  input wire [7:0] pad_slew_limit,
  input wire [7:0] pad_input_enable,
  input wire port_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Bus phases that the answer is tied to
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> s_access) else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_read_masked: assert property (pready && !pwrite && paddr[11:10] == 2'b00 |->
    (prdata & ~{24'h0, paddr[9:2]}) == 32'h0) else $error("unmasked data bit read");
  a_slew_needs_high: assert property ((pad_slew_limit & ~pad_drive_high) == 8'h00)
    else $error("slew limit without high drive");
  a_drive_exclusive: assert property (((pad_drive_low & pad_drive_mid) | (pad_drive_low & pad_drive_high)
    | (pad_drive_mid & pad_drive_high)) == 8'h00) else $error("two drive strengths on one pin");
  // Reset has to be watched while it is active, so no disable here
  a_reset_pins: assert property (disable iff (1'b0) srst |=> pin_oe == 8'h00 && pad_pulldown == 8'h00
    && pad_pullup == DEBUG_PINS && pad_input_enable == DEBUG_PINS && pad_drive_low == 8'hff && !port_irq)
    else $error("pins not at reset defaults");
endmodule
bind gpio_port gpio_port_properties #(.DEBUG_PINS(DEBUG_PINS)) gpio_port_properties_inst (.clk_sys(clk_sys),
  .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_oe(pin_oe), .pad_drive_low(pad_drive_low), .pad_drive_mid(pad_drive_mid),
  .pad_drive_high(pad_drive_high), .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown),
  .pad_slew_limit(pad_slew_limit), .pad_input_enable(pad_input_enable), .port_irq(port_irq));

// *** sim/pin_partner.sv ***
// Outside world at the pads: external drivers meet the port's own drive
`timescale 1ns/1ps
module pin_partner (
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] ext_level,
  output wire [7:0] pin_in
);
  // Port drive wins where enabled; external levels are held steady by the bench
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the port block over APB
`timescale 1ns/1ps
module tb;
  localparam [95:0] ID_VAL = 96'h0102_0304_0506_0708_090a_0b0c; // Arbitrary identification bytes
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, port_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in, ext_level;
  logic [7:0] drv_lo, drv_mid, drv_hi, odr, pu, pd, slew, ie;
  int fail_count = 0;
  int tests_run = 0;
  logic [4:0] irq_tab [7] = '{5'b00101, 5'b00110, 5'b00011, 5'b01011, 5'b01001, 5'b10101, 5'b10011};
  logic [11:0] def_a [8] = '{12'h420, 12'h510, 12'h51c, 12'h514, 12'h500, 12'h520, 12'h524, 12'h400};
  logic [7:0] def_v [8] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'hff, 8'h01, 8'h7f, 8'h00};
  gpio_port #(.DEBUG_PINS(8'h80), .ID_BYTES(ID_VAL)) gpio_port_inst (.clk_sys(clk_sys), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .pad_drive_low(drv_lo),
    .pad_drive_mid(drv_mid), .pad_drive_high(drv_hi), .pad_open_drain(odr), .pad_pullup(pu),
    .pad_pulldown(pd), .pad_slew_limit(slew), .pad_input_enable(ie), .port_irq(port_irq));
  pin_partner pin_partner_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // One transfer; an idle cycle follows so back-to-back calls never drive psel twice in a step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd_v, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
    rd_v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0, x, e);
    chk(exp, x);
  endtask
  task check_defaults;
    for (int i = 0; i < 8; i++) rd(def_a[i], {24'h0, def_v[i]});
    chk(8'h80, pu);
    chk(8'h80, ie);
    chk(8'h00, pd);
    chk(8'h00, pin_oe);
  endtask
  initial begin
    logic [31:0] x;
    logic e;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ext_level = 8'h00;
    periph_out = 8'h00;
    periph_oe = 8'h00;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check_defaults();
    // Masked data writes and reads, outputs on the pads
    wr(12'h400, 32'hff);
    wr(12'h098, 32'heb);
    rd(12'h3fc, 32'h22);
    rd(12'h0c4, 32'h20);
    chk(8'h22, pin_out & 8'h7f);
    chk(8'h7f, pin_oe & 8'h7f);
    // Open drain on pin 1, which drives a one: its enable must drop; pads lag one edge
    wr(12'h50c, 32'h02);
    @(posedge clk_sys);
    chk(8'h7d, pin_oe & 8'h7f);
    chk(8'h02, odr);
    wr(12'h50c, 32'h00);
    periph_out <= 8'h80;
    periph_oe <= 8'h80;
    repeat (3) @(posedge clk_sys);
    chk(8'h80, pin_out & pin_oe & 8'h80);
    periph_oe <= 8'h00;
    // Inputs sampled through the data register and handed to the peripheral
    wr(12'h400, 32'h00);
    wr(12'h51c, 32'hff);
    ext_level <= 8'hda;
    repeat (4) @(posedge clk_sys);
    rd(12'h1fc, 32'h5a);
    chk(8'h80, periph_in);
    // Every trigger mode on pin 0: {level, both, polarity, start, expect}
    for (int i = 0; i < 7; i++) begin
      wr(12'h410, 32'h0);
      wr(12'h404, {31'h0, irq_tab[i][4]});
      wr(12'h408, {31'h0, irq_tab[i][3]});
      wr(12'h40c, {31'h0, irq_tab[i][2]});
      ext_level <= {ext_level[7:1], irq_tab[i][1]};
      repeat (6) @(posedge clk_sys);
      wr(12'h41c, 32'hff);
      wr(12'h410, 32'h1);
      rd(12'h414, 32'h0);
      ext_level <= {ext_level[7:1], ~irq_tab[i][1]};
      repeat (6) @(posedge clk_sys);
      rd(12'h414, {31'h0, irq_tab[i][0]});
      rd(12'h418, {31'h0, irq_tab[i][0]});
      chk(irq_tab[i][0], port_irq);
      wr(12'h41c, 32'h0);
      rd(12'h414, {31'h0, irq_tab[i][0]});
      wr(12'h41c, 32'h1);
      rd(12'h414, {31'h0, irq_tab[i][0] & irq_tab[i][4]});
      wr(12'h410, 32'h0);
      rd(12'h418, 32'h0);
      chk(1'b0, port_irq);
    end
    // Guarded handover bit needs unlock and commit
    wr(12'h420, 32'h0);
    rd(12'h420, 32'h80);
    wr(12'h520, 32'h0123_4567);
    rd(12'h520, 32'h0);
    wr(12'h524, 32'hff);
    wr(12'h420, 32'h0);
    rd(12'h420, 32'h0);
    wr(12'h520, 32'h0);
    rd(12'h520, 32'h1);
    // While locked, ordinary handover bits still follow writes; the guarded one does not
    wr(12'h420, 32'h81);
    rd(12'h420, 32'h01);
    // Drive strength and slew on the pads
    wr(12'h508, 32'h01);
    rd(12'h500, 32'hfe);
    wr(12'h504, 32'h02);
    rd(12'h500, 32'hfc);
    wr(12'h518, 32'h03);
    // Pad copies update one edge after the write lands
    @(posedge clk_sys);
    chk(8'h01, slew);
    chk(8'h01, drv_hi);
    chk(8'h02, drv_mid);
    // Identification is read-only; an unmapped place answers with an error
    wr(12'hfd0, 32'hff);
    rd(12'hfd0, {24'h0, ID_VAL[7:0]});
    rd(12'hfe0, {24'h0, ID_VAL[39:32]});
    apb(1'b0, 12'h600, 32'h0, x, e);
    chk(32'h0, x);
    chk(1'b1, e);
    // Reset in mid-run restores the defaults that check_defaults reads
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check_defaults();
    final_report();
  end
endmodule
